// >>> common/vtg_pkg.sv
// Notes on behaviour
// - Control register resets to zero
// - Bits 4:3 pick crystal, PLL, pixel, inverted
// - Bit 2 pulse advances SRAM read address
// - Bit 1 returns SRAM pointer to start
// - Bit 0 low access SRAM, high run
// - Lost pixel clock falls back per PLL
// - Sleeping PLL means fallback to crystal zero
// - Digital mode: presence flag shows clock detector
// - Nonzero line total overrides 525 or 625
// - Offset 0xb0 holds low eight bits
// - Offset 0xb4 holds top two bits
// - Bits 7:4 choose odd field format
// - Bits 3:0 even format, adds raw
// - Load byte write stores only while bit 0 is low, always advances location
// - PLL integer zero sleeps the PLL
`default_nettype none
package vtg_pkg;
    localparam logic [7:0] OFS_LOAD_BYTE = 8'h80;
    localparam logic [7:0] OFS_CONTROL = 8'h84;
    localparam logic [7:0] OFS_LINE_LOW = 8'hb0;
    localparam logic [7:0] OFS_LINE_HIGH = 8'hb4;
    localparam logic [7:0] OFS_FIELD_COLOR_FORMAT = 8'hd4;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int BIT_RUN_MODE = 0;
    localparam int BIT_PTR_RESET = 1;
    localparam int BIT_READ_ADV = 2;
    localparam int CLKSEL_LSB = 3;
    localparam int ODD_LSB = 4;
    localparam logic [9:0] LINES_NTSC = 10'h20d;
    localparam logic [9:0] LINES_PAL = 10'h271;
    localparam logic [3:0] FMT_RAW = 4'he;
    localparam logic [3:0] FMT_LAST = 4'h9;
    typedef enum logic [3:0] {
        CK_XTAL = 4'h1,
        CK_PLL = 4'h2,
        CK_PIX = 4'h4,
        CK_PIX_INV = 4'h8
    } vtg_clk_type;
endpackage
`default_nettype wire

// >>> logic/vtg_sram.sv
`timescale 1ns/1ps
`default_nettype none
module vtg_sram #(
    parameter int AW = 8
) (
    input wire logic i_mclk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:(1<<AW)-1];
    always_ff @(posedge i_mclk) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule
`default_nettype wire

// >>> logic/vtg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module vtg_regs #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Register port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Decoder status
    input wire logic i_pixclk_alive,
    input wire logic i_analog_present,
    input wire logic [5:0] i_pll_integer,
    input wire logic i_pal_mode,
    input wire logic i_field_odd,
    input wire logic i_field_start,
    // Decoder controls
    output logic [3:0] o_clk_select,
    output logic o_pix_invert,
    output logic o_gen_run,
    output logic [9:0] o_lines_per_frame,
    output logic [3:0] o_active_format,
    output logic o_video_present,
    output logic [AW-1:0] o_sram_addr,
    output logic [7:0] o_sram_byte
);
    logic [7:0] ctrl_q, ctrl_d, lo_q, lo_d, hi_q, hi_d, fmt_q, fmt_d, rd_q, rd_d;
    logic [AW-1:0] ptr_q, ptr_d;
    logic [3:0] sel_q, sel_d, act_q, act_d;
    logic inv_q, inv_d, run_q, run_d, pres_q, pres_d;
    logic [9:0] lpf_q, lpf_d;
    logic [7:0] sram_q;
    logic sram_we;
    vtg_pkg::vtg_clk_type csel;
    logic [9:0] total;
    vtg_sram #(.AW(AW)) u_sram (
        .i_mclk(i_mclk),
        .i_ce(i_ce),
        .i_we(sram_we),
        .i_waddr(ptr_q),
        .i_wdata(i_wdata),
        .i_raddr(ptr_d),
        .o_rdata(sram_q)
    );
    always_comb begin
        ctrl_d = ctrl_q;
        lo_d = lo_q;
        hi_d = hi_q;
        fmt_d = fmt_q;
        ptr_d = ptr_q;
        sram_we = 1'b0;
        rd_d = rd_q;
        if (i_wr) begin
            case (i_addr)
                // Strobe bits self-clear so each write is one pulse
                vtg_pkg::OFS_CONTROL: ctrl_d = {1'b0, i_wdata[6:3], 3'h0} |
                    {7'h00, i_wdata[vtg_pkg::BIT_RUN_MODE]};
                vtg_pkg::OFS_LINE_LOW: lo_d = i_wdata;
                vtg_pkg::OFS_LINE_HIGH: hi_d = {6'h00, i_wdata[1:0]};
                vtg_pkg::OFS_FIELD_COLOR_FORMAT: fmt_d = i_wdata;
                vtg_pkg::OFS_LOAD_BYTE: begin
                    sram_we = ~ctrl_q[vtg_pkg::BIT_RUN_MODE];
                    ptr_d = ptr_q + 1'b1;
                end
                default: ;
            endcase
            if (i_addr == vtg_pkg::OFS_CONTROL) begin
                if (i_wdata[vtg_pkg::BIT_PTR_RESET]) begin
                    ptr_d = '0;
                end else if (i_wdata[vtg_pkg::BIT_READ_ADV]) begin
                    ptr_d = ptr_q + 1'b1;
                end
            end
        end
        if (i_rd) begin
            case (i_addr)
                vtg_pkg::OFS_CONTROL: rd_d = ctrl_q;
                vtg_pkg::OFS_LINE_LOW: rd_d = lo_q;
                vtg_pkg::OFS_LINE_HIGH: rd_d = hi_q;
                vtg_pkg::OFS_FIELD_COLOR_FORMAT: rd_d = fmt_q;
                vtg_pkg::OFS_LOAD_BYTE: rd_d = sram_q;
                default: rd_d = 8'h00;
            endcase
        end
    end
    always_comb begin
        case (ctrl_q[vtg_pkg::CLKSEL_LSB +: 2])
            2'b00: csel = vtg_pkg::CK_XTAL;
            2'b01: csel = vtg_pkg::CK_PLL;
            2'b10: csel = vtg_pkg::CK_PIX;
            2'b11: csel = vtg_pkg::CK_PIX_INV;
            default: csel = vtg_pkg::CK_XTAL;
        endcase
        sel_d = csel;
        inv_d = 1'b0;
        pres_d = i_analog_present;
        case (csel)
            vtg_pkg::CK_PIX, vtg_pkg::CK_PIX_INV: begin
                inv_d = (csel == vtg_pkg::CK_PIX_INV);
                pres_d = i_pixclk_alive;
                if (!i_pixclk_alive) begin
                    // Dead pixel clock: PLL if awake, else crystal zero
                    sel_d = (i_pll_integer != 6'h00) ? vtg_pkg::CK_PLL
                        : vtg_pkg::CK_XTAL;
                    inv_d = 1'b0;
                end
            end
            default: ;
        endcase
        run_d = ctrl_q[vtg_pkg::BIT_RUN_MODE];
        total = {hi_q[1:0], lo_q};
        lpf_d = (total != 10'h000) ? total
            : (i_pal_mode ? vtg_pkg::LINES_PAL : vtg_pkg::LINES_NTSC);
        act_d = act_q;
        // Format only changes at field starts so a field is never mixed
        if (i_field_start) begin
            act_d = i_field_odd ? fmt_q[vtg_pkg::ODD_LSB +: 4] : fmt_q[3:0];
        end
    end
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= vtg_pkg::RESET_VALUE;
            lo_q <= vtg_pkg::RESET_VALUE;
            hi_q <= vtg_pkg::RESET_VALUE;
            fmt_q <= vtg_pkg::RESET_VALUE;
            rd_q <= vtg_pkg::RESET_VALUE;
            ptr_q <= '0;
            sel_q <= vtg_pkg::CK_XTAL;
            inv_q <= 1'b0;
            run_q <= 1'b0;
            pres_q <= 1'b0;
            lpf_q <= vtg_pkg::LINES_NTSC;
            act_q <= 4'h0;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            fmt_q <= fmt_d;
            rd_q <= rd_d;
            ptr_q <= ptr_d;
            sel_q <= sel_d;
            inv_q <= inv_d;
            run_q <= run_d;
            pres_q <= pres_d;
            lpf_q <= lpf_d;
            act_q <= act_d;
        end
    end
    assign o_rdata = rd_q;
    assign o_clk_select = sel_q;
    assign o_pix_invert = inv_q;
    assign o_gen_run = run_q;
    assign o_lines_per_frame = lpf_q;
    assign o_active_format = act_q;
    assign o_video_present = pres_q;
    assign o_sram_addr = ptr_q;
    assign o_sram_byte = sram_q;

    AST_CTRL_RESET: assert property (@(posedge i_mclk) $rose(i_arst_n) |-> ctrl_q == 8'h00)
        else $error("control not zero after reset");
    AST_ADVANCE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_wr && i_addr == 8'h84 && i_wdata[2:1] == 2'b10 |=> ptr_q == $past(ptr_q) + 1'b1)
        else $error("read address did not advance");
    AST_PTR_CLEAR: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_wr && i_addr == 8'h84 && i_wdata[1] |=> ptr_q == '0)
        else $error("pointer not cleared");
    AST_RUN: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_wr && i_addr == vtg_pkg::OFS_CONTROL ##1 i_ce
        |=> o_gen_run == $past(i_wdata[vtg_pkg::BIT_RUN_MODE], 2))
        else $error("run mode not applied");
    AST_FALLBACK: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && ctrl_q[4] && !i_pixclk_alive && i_pll_integer == 6'h00 |=> o_clk_select == 4'h1)
        else $error("no crystal fallback");
    AST_PLL_FALLBACK: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && ctrl_q[4] && !i_pixclk_alive && i_pll_integer != 6'h00 |=> o_clk_select == 4'h2)
        else $error("no PLL fallback");
    AST_PRESENT: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && ctrl_q[4] |=> o_video_present == $past(i_pixclk_alive))
        else $error("presence not from clock detector");
    AST_LINES: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && {hi_q[1:0], lo_q} == 10'h000 && !i_pal_mode |=> o_lines_per_frame == 10'h20d)
        else $error("default line count wrong");
    AST_HIGH_RSVD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        hi_q[7:2] == 6'h00)
        else $error("reserved line bits set");
    AST_FORMAT_HOLD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        !i_field_start |=> $stable(o_active_format))
        else $error("format changed mid field");
    AST_PLL_SELECT: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && ctrl_q[vtg_pkg::CLKSEL_LSB +: 2] == 2'b01 |=> o_clk_select == vtg_pkg::CK_PLL)
        else $error("PLL not selected");
    AST_PIX_INVERT: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && ctrl_q[vtg_pkg::CLKSEL_LSB +: 2] == 2'b11 && i_pixclk_alive |=> o_pix_invert)
        else $error("inverted pixel clock not flagged");
    AST_LOAD_ADVANCE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_wr && i_addr == vtg_pkg::OFS_LOAD_BYTE |=> ptr_q == $past(ptr_q) + 1'b1)
        else $error("load byte did not advance");
    AST_PTR_HOLD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && !i_wr |=> $stable(ptr_q))
        else $error("pointer moved without a write");
    AST_LINES_PAL: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && {hi_q[1:0], lo_q} == 10'h000 && i_pal_mode
        |=> o_lines_per_frame == vtg_pkg::LINES_PAL)
        else $error("PAL default line count wrong");
    AST_LINES_OVERRIDE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && {hi_q[1:0], lo_q} != 10'h000
        |=> o_lines_per_frame == $past({hi_q[1:0], lo_q}))
        else $error("line total not applied");
    AST_ODD_FORMAT: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_field_start && i_field_odd |=> o_active_format == $past(fmt_q[7:4]))
        else $error("odd field format not applied");
    AST_EVEN_FORMAT: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_ce && i_field_start && !i_field_odd |=> o_active_format == $past(fmt_q[3:0]))
        else $error("even field format not applied");
endmodule
`default_nettype wire

// >>> sim/video_timing_gen_format_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module video_timing_gen_format_regs_tb;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_ce = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_pixclk_alive = 1'b1;
    logic i_analog_present = 1'b0;
    logic [5:0] i_pll_integer = 6'h00;
    logic i_pal_mode = 1'b0;
    logic i_field_odd = 1'b0;
    logic i_field_start = 1'b0;
    logic [7:0] o_rdata;
    logic [3:0] o_clk_select;
    logic o_pix_invert;
    logic o_gen_run;
    logic [9:0] o_lines_per_frame;
    logic [3:0] o_active_format;
    logic o_video_present;
    logic [7:0] o_sram_addr;
    logic [7:0] o_sram_byte;
    logic [3:0] od;
    logic [3:0] ev;
    int err_count = 0;
    int checks_done = 0;
    always #4 i_mclk = ~i_mclk;
    vtg_regs #(.AW(8)) i_dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_pixclk_alive(i_pixclk_alive), .i_analog_present(i_analog_present),
        .i_pll_integer(i_pll_integer), .i_pal_mode(i_pal_mode), .i_field_odd(i_field_odd),
        .i_field_start(i_field_start), .o_clk_select(o_clk_select),
        .o_pix_invert(o_pix_invert), .o_gen_run(o_gen_run),
        .o_lines_per_frame(o_lines_per_frame), .o_active_format(o_active_format),
        .o_video_present(o_video_present), .o_sram_addr(o_sram_addr),
        .o_sram_byte(o_sram_byte)
    );
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // Strobes drop just after the one edge that takes them, then two idle edges follow, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        step(1);
        i_wr = 1'b0;
        step(2);
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_rd = 1'b1;
        i_addr = a;
        step(1);
        chk({2'b00, o_rdata}, {2'b00, exp});
        i_rd = 1'b0;
        step(1);
    endtask
    task automatic field(input logic odd);
        i_field_odd = odd;
        i_field_start = 1'b1;
        step(1);
        i_field_start = 1'b0;
        step(2);
    endtask
    task automatic tally_and_finish;
        $display("mismatches=%0d comparisons=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #40000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        step(20);
        i_arst_n = 1'b1;
        step(1);
        rchk(8'h84, 8'h00);
        rchk(8'hb0, 8'h00);
        rchk(8'hb4, 8'h00);
        rchk(8'hd4, 8'h00);
        chk(o_lines_per_frame, 10'h20d);
        i_pal_mode = 1'b1;
        step(3);
        chk(o_lines_per_frame, 10'h271);
        wr(8'hb0, 8'h34);
        wr(8'hb4, 8'h02);
        chk(o_lines_per_frame, 10'h234);
        rchk(8'hb0, 8'h34);
        rchk(8'hb4, 8'h02);
        rchk(8'h88, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(8'h84, 8'(s << 3));
            chk(10'(o_clk_select), 10'(1 << s));
            chk(10'(o_pix_invert), 10'(s == 3));
        end
        rchk(8'h84, 8'h18);
        chk(10'(o_video_present), 10'h001);
        // Pixel clock dies while the PLL sleeps, then the PLL wakes
        i_pixclk_alive = 1'b0;
        step(3);
        chk(10'(o_clk_select), 10'h001);
        chk(10'(o_video_present), 10'h000);
        i_pll_integer = 6'h06;
        step(3);
        chk(10'(o_clk_select), 10'h002);
        wr(8'h84, 8'h00);
        i_analog_present = 1'b1;
        step(3);
        chk(10'(o_video_present), 10'h001);
        wr(8'h84, 8'h02);
        chk(10'(o_sram_addr), 10'h000);
        wr(8'h80, 8'ha5);
        wr(8'h80, 8'h5a);
        chk(10'(o_sram_addr), 10'h002);
        wr(8'h84, 8'h02);
        chk(10'(o_sram_addr), 10'h000);
        rchk(8'h80, 8'ha5);
        rchk(8'h80, 8'ha5);
        wr(8'h84, 8'h04);
        chk(10'(o_sram_addr), 10'h001);
        rchk(8'h80, 8'h5a);
        rchk(8'h84, 8'h00);
        wr(8'h84, 8'h01);
        chk(10'(o_gen_run), 10'h001);
        wr(8'h80, 8'hff);
        chk(10'(o_sram_addr), 10'h002);
        // Walk back to location 1: the refused byte must not have landed there
        wr(8'h84, 8'h03);
        wr(8'h84, 8'h05);
        chk(10'(o_sram_addr), 10'h001);
        chk(10'(o_sram_byte), 10'h05a);
        chk(10'(o_gen_run), 10'h001);
        i_ce = 1'b0;
        wr(8'hb0, 8'h77);
        i_ce = 1'b1;
        rchk(8'hb0, 8'h34);
        // Mid-run reset while the run bit is set
        i_arst_n = 1'b0;
        step(2);
        i_arst_n = 1'b1;
        step(1);
        rchk(8'h84, 8'h00);
        rchk(8'hb0, 8'h00);
        chk(o_lines_per_frame, 10'h271);
        wr(8'hd4, 8'h9e);
        chk(10'(o_active_format), 10'h000);
        for (int c = 0; c < 11; c++) begin
            ev = (c == 10) ? 4'he : 4'(c);
            od = (c == 10) ? 4'h0 : 4'(9 - c);
            wr(8'hd4, {od, ev});
            field(1'b1);
            chk(10'(o_active_format), 10'(od));
            field(1'b0);
            chk(10'(o_active_format), 10'(ev));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
